/* File: verification/dtc_pin_model.sv */
/*
 Far-side model: external request, gate and count pins plus interrupt-entry pulses.
 Assumes the bench calls its tasks and that all pins idle high, as with pull-ups.
*/
`timescale 1ns/100ps
`default_nettype none

module dtc_pin_model (
	input wire logic clk_i,
	output logic [3:0] pins_o,
	output logic [3:0] enter_o
);
	// Idle levels at time zero
	initial begin
		pins_o = 4'hF;
		enter_o = 4'h0;
	end

	// Hold a pin at a level; pins change just after an edge
	task automatic set_pin(input int p, input logic v);
		@(posedge clk_i);
		pins_o[p] <= v;
	endtask

	// One falling edge, two cycles low and two high so the synchroniser sees it
	task automatic fall(input int p);
		set_pin(p, 1'b0);
		repeat (2) @(posedge clk_i);
		pins_o[p] <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask

	// One-cycle interrupt-entry pulse
	task automatic enter(input int e);
		@(posedge clk_i);
		enter_o[e] <= 1'b1;
		@(posedge clk_i);
		enter_o[e] <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: verification/dtc_timer_pair_tb_top.sv */
/*
 Self-checking bench for the timer pair: APB register access and pin stimulus.
 Assumes the register map of dtc_pkg and the one-wait-state APB slave.
*/
`timescale 1ns/100ps
`default_nettype none

module dtc_timer_pair_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, ovf_a, ovf_b, ext_a, ext_b, baud;
	logic [3:0] pins, ent;
	logic [7:0] rd;
	logic er;
	int err_total = 0;
	int comparisons = 0;
	int baud_cnt = 0;

	// 200 MHz system clock
	always #2.5 clk = ~clk;

	dtc_timer_pair dtc_timer_pair_i (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .EXT_IRQ_A_PIN_I(pins[0]), .EXT_IRQ_B_PIN_I(pins[1]),
		.COUNT_IN_A_PIN_I(pins[2]), .COUNT_IN_B_PIN_I(pins[3]), .IRQ_ENTER_OVF_A_I(ent[0]),
		.IRQ_ENTER_OVF_B_I(ent[1]), .IRQ_ENTER_EXT_A_I(ent[2]), .IRQ_ENTER_EXT_B_I(ent[3]),
		.OVF_FLAG_A_O(ovf_a), .OVF_FLAG_B_O(ovf_b), .EXT_IRQ_A_FLAG_O(ext_a),
		.EXT_IRQ_B_FLAG_O(ext_b), .BAUD_TICK_B_O(baud));

	dtc_pin_model dtc_pin_model_i (.clk_i(clk), .pins_o(pins), .enter_o(ent));

	// Baud pulses counted as they leave the block
	always @(posedge clk) if (baud === 1'b1) baud_cnt++;

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the request stands until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, dtc_pkg::ADDR_ALIGN};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// A slave that never answers ends the run as a failure
		if (n >= 20) begin
			err_total++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(name, rd, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end

	initial begin
		logic [7:0] idx_t [4] = '{dtc_pkg::IDX_A_LOW, dtc_pkg::IDX_A_HIGH, dtc_pkg::IDX_B_LOW, dtc_pkg::IDX_B_HIGH};
		cyc(5);
		rst <= 1'b0;
		rchk("ctrl_rst", dtc_pkg::IDX_CTRL, 8'h00);
		rchk("mode_rst", dtc_pkg::IDX_MODE, 8'h00);
		apb(1'b0, 8'h8E, 8'h00);
		chk("unmapped_err", {7'h00, er}, 8'h01);
		// Each count byte holds its own value
		for (int i = 0; i < 4; i++) wr(idx_t[i], 8'h5A ^ 8'(i));
		for (int i = 0; i < 4; i++) rchk("count_byte", idx_t[i], 8'h5A ^ 8'(i));
		// Mode 0: 13-bit wrap leaves the low byte's top bits alone
		wr(dtc_pkg::IDX_A_HIGH, 8'hFF);
		wr(dtc_pkg::IDX_A_LOW, 8'hFF);
		wr(dtc_pkg::IDX_MODE, 8'h00);
		wr(dtc_pkg::IDX_CTRL, 8'h10);
		cyc(6);
		chk("ovf_a_m0", {7'h00, ovf_a}, 8'h01);
		wr(dtc_pkg::IDX_CTRL, 8'h20);
		apb(1'b0, dtc_pkg::IDX_A_LOW, 8'h00);
		chk("a_low_top", {5'h00, rd[7:5]}, 8'h07);
		rchk("a_high_m0", dtc_pkg::IDX_A_HIGH, 8'h00);
		dtc_pin_model_i.enter(0);
		cyc(1);
		chk("ovf_a_enter", {7'h00, ovf_a}, 8'h00);
		// Mode 2: low byte reloads from high byte
		wr(dtc_pkg::IDX_A_HIGH, 8'hF0);
		wr(dtc_pkg::IDX_A_LOW, 8'hFE);
		wr(dtc_pkg::IDX_MODE, 8'h02);
		wr(dtc_pkg::IDX_CTRL, 8'h10);
		cyc(30);
		wr(dtc_pkg::IDX_CTRL, 8'h00);
		rchk("a_high_m2", dtc_pkg::IDX_A_HIGH, 8'hF0);
		apb(1'b0, dtc_pkg::IDX_A_LOW, 8'h00);
		chk("a_low_m2", {4'h0, rd[7:4]}, 8'h0F);
		// Counting mode on both timers: one step per pin falling edge
		wr(dtc_pkg::IDX_A_LOW, 8'h00);
		wr(dtc_pkg::IDX_B_LOW, 8'h00);
		wr(dtc_pkg::IDX_MODE, 8'h55);
		wr(dtc_pkg::IDX_CTRL, 8'h50);
		for (int i = 0; i < 3; i++) dtc_pin_model_i.fall(2);
		for (int i = 0; i < 2; i++) dtc_pin_model_i.fall(3);
		cyc(4);
		wr(dtc_pkg::IDX_CTRL, 8'h00);
		rchk("a_cnt", dtc_pkg::IDX_A_LOW, 8'h03);
		rchk("b_cnt", dtc_pkg::IDX_B_LOW, 8'h02);
		// Gate closed by a low request pin; level mode raises the request flag
		wr(dtc_pkg::IDX_MODE, 8'h09);
		wr(dtc_pkg::IDX_A_LOW, 8'h55);
		dtc_pin_model_i.set_pin(0, 1'b0);
		cyc(4);
		wr(dtc_pkg::IDX_CTRL, 8'h10);
		cyc(20);
		chk("ext_a_level", {7'h00, ext_a}, 8'h01);
		wr(dtc_pkg::IDX_CTRL, 8'h00);
		rchk("a_gated", dtc_pkg::IDX_A_LOW, 8'h55);
		dtc_pin_model_i.set_pin(0, 1'b1);
		cyc(4);
		dtc_pin_model_i.enter(2);
		cyc(1);
		chk("ext_a_enter", {7'h00, ext_a}, 8'h00);
		// Falling-edge requests on both pins
		for (int i = 0; i < 2; i++) begin
			wr(dtc_pkg::IDX_CTRL, i == 0 ? 8'h01 : 8'h04);
			dtc_pin_model_i.fall(i);
			cyc(4);
			chk("ext_edge", {7'h00, i == 0 ? ext_a : ext_b}, 8'h01);
			dtc_pin_model_i.enter(2 + i);
			cyc(1);
			chk("ext_edge_enter", {7'h00, i == 0 ? ext_a : ext_b}, 8'h00);
		end
		// Timer B 16-bit wrap: flag, one baud pulse, software clear
		wr(dtc_pkg::IDX_MODE, 8'h10);
		wr(dtc_pkg::IDX_B_HIGH, 8'hFF);
		wr(dtc_pkg::IDX_B_LOW, 8'hFE);
		baud_cnt = 0;
		wr(dtc_pkg::IDX_CTRL, 8'h40);
		cyc(10);
		chk("ovf_b", {7'h00, ovf_b}, 8'h01);
		wr(dtc_pkg::IDX_CTRL, 8'h80);
		chk("baud_cnt", 8'(baud_cnt), 8'h01);
		wr(dtc_pkg::IDX_CTRL, 8'h00);
		cyc(1);
		chk("ovf_b_sw", {7'h00, ovf_b}, 8'h00);
		// Timer B in mode 3 holds
		wr(dtc_pkg::IDX_MODE, 8'h30);
		wr(dtc_pkg::IDX_B_LOW, 8'h10);
		wr(dtc_pkg::IDX_CTRL, 8'h40);
		cyc(10);
		wr(dtc_pkg::IDX_CTRL, 8'h00);
		rchk("b_mode3", dtc_pkg::IDX_B_LOW, 8'h10);
		// Gated counting on timer B: a count edge with pin B low is ignored
		wr(dtc_pkg::IDX_MODE, 8'hD0);
		wr(dtc_pkg::IDX_B_LOW, 8'h20);
		wr(dtc_pkg::IDX_CTRL, 8'h40);
		dtc_pin_model_i.set_pin(1, 1'b0);
		cyc(3);
		dtc_pin_model_i.fall(3);
		dtc_pin_model_i.set_pin(1, 1'b1);
		cyc(3);
		dtc_pin_model_i.fall(3);
		cyc(4);
		wr(dtc_pkg::IDX_CTRL, 8'h00);
		rchk("b_gated", dtc_pkg::IDX_B_LOW, 8'h21);
		// Timer A split: high half runs on timer B's run bit and sets B's flag
		wr(dtc_pkg::IDX_A_LOW, 8'h33);
		wr(dtc_pkg::IDX_A_HIGH, 8'hFE);
		wr(dtc_pkg::IDX_MODE, 8'h03);
		wr(dtc_pkg::IDX_CTRL, 8'h40);
		cyc(4);
		chk("ovf_b_split", {7'h00, ovf_b}, 8'h01);
		chk("ovf_a_split", {7'h00, ovf_a}, 8'h00);
		dtc_pin_model_i.enter(1);
		cyc(1);
		chk("ovf_b_enter", {7'h00, ovf_b}, 8'h00);
		wr(dtc_pkg::IDX_CTRL, 8'h00);
		rchk("a_low_split", dtc_pkg::IDX_A_LOW, 8'h33);
		report_and_stop();
	end
endmodule

`default_nettype wire

/* File: verilog/dtc_count_step.sv */
/*
 Next-count logic of one timer for the four mode codes.
 Assumes the caller gives one-cycle count ticks and registers the result.
*/
`timescale 1ns/100ps
`default_nettype none

module dtc_count_step (
	input wire logic [1:0] mode_i,
	input wire logic tick_i,
	input wire logic tick_hi_i,
	input wire logic [7:0] low_i,
	input wire logic [7:0] high_i,
	output logic [7:0] next_low_o,
	output logic [7:0] next_high_o,
	output logic ovf_o,
	output logic ovf_hi_o
);
	logic [13:0] sum13;
	logic [16:0] sum16;
	logic [8:0] sum_lo;
	logic [8:0] sum_hi;

	// Adders are one bit wider so the carry marks the all-ones wrap
	always_comb begin
		sum13 = {1'b0, high_i, low_i[4:0]} + 14'h0001;
		sum16 = {1'b0, high_i, low_i} + 17'h00001;
		sum_lo = {1'b0, low_i} + 9'h001;
		sum_hi = {1'b0, high_i} + 9'h001;
		next_low_o = low_i;
		next_high_o = high_i;
		ovf_o = 1'b0;
		ovf_hi_o = 1'b0;
		case (mode_i)
			dtc_pkg::MODE_13BIT: begin
				if (tick_i) begin
					next_low_o = {low_i[7:5], sum13[4:0]}; // Top three bits untouched
					next_high_o = sum13[12:5];
					ovf_o = sum13[13];
				end
			end
			dtc_pkg::MODE_16BIT: begin
				if (tick_i) begin
					next_low_o = sum16[7:0];
					next_high_o = sum16[15:8];
					ovf_o = sum16[16];
				end
			end
			dtc_pkg::MODE_RELOAD8: begin
				if (tick_i) begin
					next_low_o = sum_lo[8] ? high_i : sum_lo[7:0];
					ovf_o = sum_lo[8];
				end
			end
			dtc_pkg::MODE_SPLIT: begin
				if (tick_i) begin
					next_low_o = sum_lo[7:0];
					ovf_o = sum_lo[8];
				end
				if (tick_hi_i) begin
					next_high_o = sum_hi[7:0];
					ovf_hi_o = sum_hi[8];
				end
			end
			default: begin
				ovf_o = 1'b0;
			end
		endcase
	end
endmodule

`default_nettype wire

/* File: verilog/dtc_pin_if.sv */
/*
 Carrier for the synchronised pin levels and their falling-edge pulses.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface dtc_pin_if;
	logic [dtc_pkg::PIN_N-1:0] level;
	logic [dtc_pkg::PIN_N-1:0] fall;

	modport drv (output level, output fall);
	modport use_side (input level, input fall);
endinterface

`default_nettype wire

/* File: verilog/dtc_pin_sync.sv */
/*
 Two-stage synchronisers and falling-edge detectors for the external pins.
 Assumes the pins are asynchronous to the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

module dtc_pin_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [dtc_pkg::PIN_N-1:0] pins_i,
	dtc_pin_if.drv pin_o
);
	dtc_pkg::dtc_sync_s r;
	dtc_pkg::dtc_sync_s next_r;

	// Stage one feeds stage two only; edges are judged on settled samples
	always_comb begin
		next_r = r;
		next_r.stage1 = pins_i;
		next_r.stage2 = r.stage1;
		next_r.prev = r.stage2;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			// Idle-high reset level, so no false low request or edge follows reset
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	// Per-pin level and one-cycle falling pulse
	genvar g;
	generate
		for (g = 0; g < dtc_pkg::PIN_N; g = g + 1) begin : g_pin
			assign pin_o.level[g] = r.stage2[g];
			assign pin_o.fall[g] = r.prev[g] & ~r.stage2[g];
		end
	endgenerate
endmodule

`default_nettype wire

/* File: verilog/dtc_pkg.sv */
/*
 Shared constants and types of the dual timer/counter pair: register indices,
 field positions, mode codes, reset values and the state records.
 Assumes a register bus that places each register index at byte address 4*index.
*/
`default_nettype none

package dtc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h88;
	localparam logic [7:0] IDX_MODE = 8'h89;
	localparam logic [7:0] IDX_A_LOW = 8'h8A;
	localparam logic [7:0] IDX_B_LOW = 8'h8B;
	localparam logic [7:0] IDX_A_HIGH = 8'h8C;
	localparam logic [7:0] IDX_B_HIGH = 8'h8D;
	localparam logic [1:0] ADDR_ALIGN = 2'h0;

	// Control register fields
	localparam int CTRL_OVF_B = 7;
	localparam int CTRL_RUN_B = 6;
	localparam int CTRL_OVF_A = 5;
	localparam int CTRL_RUN_A = 4;
	localparam int CTRL_EXT_B_FLAG = 3;
	localparam int CTRL_EXT_B_EDGE = 2;
	localparam int CTRL_EXT_A_FLAG = 1;
	localparam int CTRL_EXT_A_EDGE = 0;

	// Mode register fields
	localparam int MODE_GATE_B = 7;
	localparam int MODE_CSEL_B = 6;
	localparam int MODE_SEL_B_HI = 5;
	localparam int MODE_SEL_B_LO = 4;
	localparam int MODE_GATE_A = 3;
	localparam int MODE_CSEL_A = 2;
	localparam int MODE_SEL_A_HI = 1;
	localparam int MODE_SEL_A_LO = 0;

	// Mode field codes
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [23:0] RDATA_PAD = 24'h000000;

	// Pin positions in the synchroniser vector
	localparam int PIN_N = 4;
	localparam int PIN_IRQ_A = 0;
	localparam int PIN_IRQ_B = 1;
	localparam int PIN_CNT_A = 2;
	localparam int PIN_CNT_B = 3;

	typedef enum logic [0:0] {
		DTC_APB_IDLE = 1'b0,
		DTC_APB_RESP = 1'b1
	} dtc_apb_e;

	typedef struct packed {
		logic [PIN_N-1:0] stage1;
		logic [PIN_N-1:0] stage2;
		logic [PIN_N-1:0] prev;
	} dtc_sync_s;

	typedef struct packed {
		dtc_apb_e apb_st;
		logic [7:0] ctrl;
		logic [7:0] mode_cfg;
		logic [7:0] a_low;
		logic [7:0] a_high;
		logic [7:0] b_low;
		logic [7:0] b_high;
		logic [7:0] rdata;
		logic slverr;
		logic baud_tick;
	} dtc_state_s;

endpackage

`default_nettype wire

/* File: verilog/dtc_timer_pair.sv */
/*
 Dual 16-bit timer/counter pair with control and mode registers on APB.
 Assumes an APB master on the system clock, asynchronous external pins, and
 one-cycle interrupt-entry pulses from the interrupt controller on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module dtc_timer_pair (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [9:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic EXT_IRQ_A_PIN_I,
	input wire logic EXT_IRQ_B_PIN_I,
	input wire logic COUNT_IN_A_PIN_I,
	input wire logic COUNT_IN_B_PIN_I,
	input wire logic IRQ_ENTER_OVF_A_I,
	input wire logic IRQ_ENTER_OVF_B_I,
	input wire logic IRQ_ENTER_EXT_A_I,
	input wire logic IRQ_ENTER_EXT_B_I,
	output logic OVF_FLAG_A_O,
	output logic OVF_FLAG_B_O,
	output logic EXT_IRQ_A_FLAG_O,
	output logic EXT_IRQ_B_FLAG_O,
	output logic BAUD_TICK_B_O
);
	dtc_pkg::dtc_state_s r;
	dtc_pkg::dtc_state_s next_r;

	dtc_pin_if pins ();

	logic [1:0] mode_a;
	logic [1:0] mode_b;
	logic split_a;
	logic run_a_eff;
	logic run_b_eff;
	logic tick_a;
	logic tick_a_hi;
	logic tick_b;
	logic [7:0] step_a_low;
	logic [7:0] step_a_high;
	logic [7:0] step_b_low;
	logic [7:0] step_b_high;
	logic ovf_a_main;
	logic ovf_a_hi;
	logic ovf_b_main;
	logic ovf_b_hi;
	logic ovf_a_evt;
	logic ovf_b_set;
	logic ext_a_req;
	logic ext_b_req;
	logic hit;
	logic [7:0] rd_val;
	logic access;
	logic wr;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_a_low;
	logic wr_a_high;
	logic wr_b_low;
	logic wr_b_high;
	logic [7:0] wdata;

	// Pin conditioning; nothing reads a raw pin
	dtc_pin_sync u_sync (
		.clk_i(CLK_SYS_I),
		.rst_i(RST_I),
		.pins_i({COUNT_IN_B_PIN_I, COUNT_IN_A_PIN_I, EXT_IRQ_B_PIN_I, EXT_IRQ_A_PIN_I}),
		.pin_o(pins)
	);

	// Mode fields and count enables
	assign mode_a = {r.mode_cfg[dtc_pkg::MODE_SEL_A_HI], r.mode_cfg[dtc_pkg::MODE_SEL_A_LO]};
	assign mode_b = {r.mode_cfg[dtc_pkg::MODE_SEL_B_HI], r.mode_cfg[dtc_pkg::MODE_SEL_B_LO]};
	assign split_a = (mode_a == dtc_pkg::MODE_SPLIT);
	assign run_a_eff = r.ctrl[dtc_pkg::CTRL_RUN_A]
		& (~r.mode_cfg[dtc_pkg::MODE_GATE_A] | pins.level[dtc_pkg::PIN_IRQ_A]);
	// In split mode the B run bit belongs to A's high half, so B free-runs on its gate
	assign run_b_eff = (split_a | r.ctrl[dtc_pkg::CTRL_RUN_B])
		& (~r.mode_cfg[dtc_pkg::MODE_GATE_B] | pins.level[dtc_pkg::PIN_IRQ_B]);
	assign tick_a = run_a_eff
		& (~r.mode_cfg[dtc_pkg::MODE_CSEL_A] | pins.fall[dtc_pkg::PIN_CNT_A]);
	assign tick_b = run_b_eff & (mode_b != dtc_pkg::MODE_SPLIT)
		& (~r.mode_cfg[dtc_pkg::MODE_CSEL_B] | pins.fall[dtc_pkg::PIN_CNT_B]);
	assign tick_a_hi = split_a & r.ctrl[dtc_pkg::CTRL_RUN_B];

	// One step per timer; B's high-half input is unused
	dtc_count_step u_step_a (
		.mode_i(mode_a),
		.tick_i(tick_a),
		.tick_hi_i(tick_a_hi),
		.low_i(r.a_low),
		.high_i(r.a_high),
		.next_low_o(step_a_low),
		.next_high_o(step_a_high),
		.ovf_o(ovf_a_main),
		.ovf_hi_o(ovf_a_hi)
	);

	dtc_count_step u_step_b (
		.mode_i(mode_b),
		.tick_i(tick_b),
		.tick_hi_i(1'b0),
		.low_i(r.b_low),
		.high_i(r.b_high),
		.next_low_o(step_b_low),
		.next_high_o(step_b_high),
		.ovf_o(ovf_b_main),
		.ovf_hi_o(ovf_b_hi)
	);

	// Flag sources; A's high half takes over B's flag in split mode
	assign ovf_a_evt = ovf_a_main;
	assign ovf_b_set = split_a ? ovf_a_hi : (ovf_b_main | ovf_b_hi);
	assign ext_a_req = r.ctrl[dtc_pkg::CTRL_EXT_A_EDGE] ? pins.fall[dtc_pkg::PIN_IRQ_A]
		: ~pins.level[dtc_pkg::PIN_IRQ_A];
	assign ext_b_req = r.ctrl[dtc_pkg::CTRL_EXT_B_EDGE] ? pins.fall[dtc_pkg::PIN_IRQ_B]
		: ~pins.level[dtc_pkg::PIN_IRQ_B];

	// Bus decode, register update and counting in one pass
	always_comb begin
		next_r = r;
		next_r.baud_tick = ovf_b_main;
		hit = 1'b0;
		rd_val = 8'h00;
		access = PSEL_I & PENABLE_I;
		wdata = PWDATA_I[7:0];
		if (PADDR_I[1:0] == dtc_pkg::ADDR_ALIGN) begin
			hit = 1'b1;
			case (PADDR_I[9:2])
				dtc_pkg::IDX_CTRL: rd_val = r.ctrl;
				dtc_pkg::IDX_MODE: rd_val = r.mode_cfg;
				dtc_pkg::IDX_A_LOW: rd_val = r.a_low;
				dtc_pkg::IDX_A_HIGH: rd_val = r.a_high;
				dtc_pkg::IDX_B_LOW: rd_val = r.b_low;
				dtc_pkg::IDX_B_HIGH: rd_val = r.b_high;
				default: hit = 1'b0;
			endcase
		end
		wr = access & PWRITE_I & hit & (r.apb_st == dtc_pkg::DTC_APB_RESP);
		wr_ctrl = wr & (PADDR_I[9:2] == dtc_pkg::IDX_CTRL);
		wr_mode = wr & (PADDR_I[9:2] == dtc_pkg::IDX_MODE);
		wr_a_low = wr & (PADDR_I[9:2] == dtc_pkg::IDX_A_LOW);
		wr_a_high = wr & (PADDR_I[9:2] == dtc_pkg::IDX_A_HIGH);
		wr_b_low = wr & (PADDR_I[9:2] == dtc_pkg::IDX_B_LOW);
		wr_b_high = wr & (PADDR_I[9:2] == dtc_pkg::IDX_B_HIGH);

		// One wait state: read data is captured in the first access cycle, writes land in the second
		case (r.apb_st)
			dtc_pkg::DTC_APB_IDLE: begin
				if (access) begin
					next_r.apb_st = dtc_pkg::DTC_APB_RESP;
					next_r.rdata = hit ? rd_val : 8'h00;
					next_r.slverr = ~hit;
				end
			end
			dtc_pkg::DTC_APB_RESP: begin
				next_r.apb_st = dtc_pkg::DTC_APB_IDLE;
				next_r.slverr = 1'b0;
			end
			default: begin
				next_r.apb_st = dtc_pkg::DTC_APB_IDLE;
			end
		endcase

		// Counting first, so a software byte write overrides the step
		next_r.a_low = wr_a_low ? wdata : step_a_low;
		next_r.a_high = wr_a_high ? wdata : step_a_high;
		next_r.b_low = wr_b_low ? wdata : step_b_low;
		next_r.b_high = wr_b_high ? wdata : step_b_high;
		if (wr_mode) begin
			next_r.mode_cfg = wdata;
		end

		// Write, then entry clears, then hardware sets: a set is never lost
		if (wr_ctrl) begin
			next_r.ctrl = wdata;
		end
		if (IRQ_ENTER_OVF_B_I) begin
			next_r.ctrl[dtc_pkg::CTRL_OVF_B] = 1'b0;
		end
		if (IRQ_ENTER_OVF_A_I) begin
			next_r.ctrl[dtc_pkg::CTRL_OVF_A] = 1'b0;
		end
		if (IRQ_ENTER_EXT_B_I) begin
			next_r.ctrl[dtc_pkg::CTRL_EXT_B_FLAG] = 1'b0;
		end
		if (IRQ_ENTER_EXT_A_I) begin
			next_r.ctrl[dtc_pkg::CTRL_EXT_A_FLAG] = 1'b0;
		end
		if (ovf_b_set) begin
			next_r.ctrl[dtc_pkg::CTRL_OVF_B] = 1'b1;
		end
		if (ovf_a_evt) begin
			next_r.ctrl[dtc_pkg::CTRL_OVF_A] = 1'b1;
		end
		if (ext_b_req) begin
			next_r.ctrl[dtc_pkg::CTRL_EXT_B_FLAG] = 1'b1;
		end
		if (ext_a_req) begin
			next_r.ctrl[dtc_pkg::CTRL_EXT_A_FLAG] = 1'b1;
		end
	end

	// Registers; count bytes are given zero at reset for determinism
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			r.apb_st <= dtc_pkg::DTC_APB_IDLE;
			r.ctrl <= dtc_pkg::CTRL_RST;
			r.mode_cfg <= dtc_pkg::MODE_RST;
			r.a_low <= dtc_pkg::COUNT_RST;
			r.a_high <= dtc_pkg::COUNT_RST;
			r.b_low <= dtc_pkg::COUNT_RST;
			r.b_high <= dtc_pkg::COUNT_RST;
			r.rdata <= dtc_pkg::COUNT_RST;
			r.slverr <= 1'b0;
			r.baud_tick <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from state
	assign PRDATA_O = {dtc_pkg::RDATA_PAD, r.rdata};
	assign PREADY_O = (r.apb_st == dtc_pkg::DTC_APB_RESP);
	assign PSLVERR_O = r.slverr;
	assign OVF_FLAG_A_O = r.ctrl[dtc_pkg::CTRL_OVF_A];
	assign OVF_FLAG_B_O = r.ctrl[dtc_pkg::CTRL_OVF_B];
	assign EXT_IRQ_A_FLAG_O = r.ctrl[dtc_pkg::CTRL_EXT_A_FLAG];
	assign EXT_IRQ_B_FLAG_O = r.ctrl[dtc_pkg::CTRL_EXT_B_FLAG];
	assign BAUD_TICK_B_O = r.baud_tick;

	// Checks on the flag, counting and bus behaviour
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	// Flags: a set in the same cycle outranks entry and software clears
	ovf_b_set_a: assert property (ovf_b_set |=> OVF_FLAG_B_O)
		else $error("timer B overflow did not set its flag");
	ovf_b_clear_a: assert property (IRQ_ENTER_OVF_B_I && !ovf_b_set && !wr_ctrl |=> !OVF_FLAG_B_O)
		else $error("timer B flag survived interrupt entry");
	ovf_a_set_a: assert property (ovf_a_evt |=> OVF_FLAG_A_O)
		else $error("timer A overflow did not set its flag");
	ovf_a_clear_a: assert property (IRQ_ENTER_OVF_A_I && !ovf_a_evt && !wr_ctrl |=> !OVF_FLAG_A_O)
		else $error("timer A flag survived interrupt entry");
	ext_b_clear_a: assert property (IRQ_ENTER_EXT_B_I && !ext_b_req && !wr_ctrl |=> !EXT_IRQ_B_FLAG_O)
		else $error("pin B flag survived interrupt entry");
	ext_a_clear_a: assert property (IRQ_ENTER_EXT_A_I && !ext_a_req && !wr_ctrl |=> !EXT_IRQ_A_FLAG_O)
		else $error("pin A flag survived interrupt entry");
	ext_a_level_a: assert property (!r.ctrl[dtc_pkg::CTRL_EXT_A_EDGE] && !pins.level[dtc_pkg::PIN_IRQ_A]
		|=> EXT_IRQ_A_FLAG_O)
		else $error("low level on pin A did not raise its flag");
	ext_b_level_a: assert property (!r.ctrl[dtc_pkg::CTRL_EXT_B_EDGE] && !pins.level[dtc_pkg::PIN_IRQ_B]
		|=> EXT_IRQ_B_FLAG_O)
		else $error("low level on pin B did not raise its flag");
	ext_b_edge_a: assert property (r.ctrl[dtc_pkg::CTRL_EXT_B_EDGE] && pins.fall[dtc_pkg::PIN_IRQ_B]
		|=> EXT_IRQ_B_FLAG_O)
		else $error("falling edge on pin B did not raise its flag");
	ext_a_edge_a: assert property (r.ctrl[dtc_pkg::CTRL_EXT_A_EDGE] && pins.fall[dtc_pkg::PIN_IRQ_A]
		|=> EXT_IRQ_A_FLAG_O)
		else $error("falling edge on pin A did not raise its flag");

	// Run bits belong to software alone
	run_b_hold_a: assert property (!wr_ctrl |=> $stable(r.ctrl[dtc_pkg::CTRL_RUN_B]))
		else $error("timer B run bit changed without a write");
	run_a_hold_a: assert property (!wr_ctrl |=> $stable(r.ctrl[dtc_pkg::CTRL_RUN_A]))
		else $error("timer A run bit changed without a write");

	// Gates and count pins hold the count while closed or quiet
	gate_a_hold_a: assert property (r.mode_cfg[dtc_pkg::MODE_GATE_A] && !pins.level[dtc_pkg::PIN_IRQ_A]
		&& !split_a && !wr_a_low && !wr_a_high |=> $stable(r.a_low) && $stable(r.a_high))
		else $error("gated timer A counted with pin low");
	gate_b_hold_a: assert property (r.mode_cfg[dtc_pkg::MODE_GATE_B] && !pins.level[dtc_pkg::PIN_IRQ_B]
		&& !wr_b_low && !wr_b_high |=> $stable(r.b_low) && $stable(r.b_high))
		else $error("gated timer B counted with pin low");
	count_pin_a_a: assert property (r.mode_cfg[dtc_pkg::MODE_CSEL_A] && !pins.fall[dtc_pkg::PIN_CNT_A]
		&& !wr_a_low |=> $stable(r.a_low))
		else $error("timer A counted without a pin edge");
	count_pin_b_a: assert property (r.mode_cfg[dtc_pkg::MODE_CSEL_B] && !pins.fall[dtc_pkg::PIN_CNT_B]
		&& !wr_b_low |=> $stable(r.b_low))
		else $error("timer B counted without a pin edge");

	// Mode behaviour of the counting units
	wrap13_a: assert property (mode_a == dtc_pkg::MODE_13BIT && tick_a && r.a_high == 8'hFF
		&& r.a_low[4:0] == 5'h1F && !wr_a_low && !wr_a_high
		|=> r.a_high == 8'h00 && r.a_low[4:0] == 5'h00 && r.a_low[7:5] == $past(r.a_low[7:5]) && OVF_FLAG_A_O)
		else $error("13-bit wrap of timer A wrong");
	wrap16_a: assert property (mode_a == dtc_pkg::MODE_16BIT && tick_a && r.a_low == 8'hFF && r.a_high == 8'hFF
		&& !wr_a_low && !wr_a_high |=> r.a_low == 8'h00 && r.a_high == 8'h00 && OVF_FLAG_A_O)
		else $error("16-bit wrap of timer A wrong");
	reload8_a: assert property (mode_a == dtc_pkg::MODE_RELOAD8 && tick_a && r.a_low == 8'hFF
		&& !wr_a_low && !wr_a_high |=> r.a_low == $past(r.a_high) && OVF_FLAG_A_O)
		else $error("8-bit reload of timer A wrong");
	split_hi_a: assert property (split_a && tick_a_hi && !wr_a_high
		|=> r.a_high == $past(r.a_high) + 8'h01)
		else $error("high half of split timer A did not advance");
	b_split_stop_a: assert property (mode_b == dtc_pkg::MODE_SPLIT && !wr_b_low && !wr_b_high
		|=> $stable(r.b_low) && $stable(r.b_high))
		else $error("timer B counted in mode 3");
	timing_step_a: assert property (mode_a == dtc_pkg::MODE_16BIT && !r.mode_cfg[dtc_pkg::MODE_CSEL_A]
		&& run_a_eff && r.a_low != 8'hFF && !wr_a_low |=> r.a_low == $past(r.a_low) + 8'h01)
		else $error("timer A did not advance once per clock");
	baud_tick_a: assert property (BAUD_TICK_B_O == $past(ovf_b_main))
		else $error("baud pulse does not follow timer B overflow");

	// Bus answer timing, refusal and write priority
	apb_ready_a: assert property (access && !PREADY_O |=> PREADY_O ##1 !PREADY_O)
		else $error("APB answer not after one wait state");
	apb_err_a: assert property (access && !PREADY_O && !hit |=> PSLVERR_O && PRDATA_O == 32'h00000000)
		else $error("unmapped access not refused");
	apb_wr_a: assert property (wr_a_low |=> r.a_low == $past(wdata))
		else $error("byte write to timer A low lost");

	mode0_ovf_c: cover property (mode_a == dtc_pkg::MODE_13BIT && ovf_a_evt);
	split_hi_c: cover property (split_a && ovf_a_hi);
	ext_edge_c: cover property (r.ctrl[dtc_pkg::CTRL_EXT_A_EDGE] && pins.fall[dtc_pkg::PIN_IRQ_A]);
	split_b_c: cover property (mode_b == dtc_pkg::MODE_SPLIT && run_b_eff);
	apb_write_c: cover property (wr_mode ##[1:8] wr_ctrl);
endmodule

`default_nettype wire
